// ===== verilog/isr_regs.svh
`ifndef ISR_REGS_SVH
`define ISR_REGS_SVH

// slave address with the address-select pin low, and with it high
`define ISR_SLAVE_ADDR_LOW 7'h18
`define ISR_SLAVE_ADDR_HIGH 7'h19
// read start address after reset, before any register address is written
`define ISR_START_ADDR_RST 8'h00
// bits in one byte on the wire
`define ISR_BYTE_BITS 4'h8
// core clock rate in MHz
`define ISR_CLK_MHZ 100
// watchdog timeout periods in microseconds, short and long setting
`define ISR_WDT_SHORT_US 1000
`define ISR_WDT_LONG_US 50000
// watchdog periods in core clock cycles
`define ISR_WDT_SHORT_CYC (`ISR_WDT_SHORT_US * `ISR_CLK_MHZ)
`define ISR_WDT_LONG_CYC (`ISR_WDT_LONG_US * `ISR_CLK_MHZ)

`endif

// ===== verilog/isr_pkg.sv
package isr_pkg;

  // protocol position of the slave engine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_MACK,
    ST_WAIT
  } isr_state_t;

  // one register write handed to the register file
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } isr_wr_t;

endpackage : isr_pkg

// ===== verilog/isr_watchdog.sv
`timescale 1ns/1ps
`include "isr_regs.svh"

module isr_watchdog #(
  parameter int SHORT_CYC = `ISR_WDT_SHORT_CYC,
  parameter int LONG_CYC = `ISR_WDT_LONG_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic longSel,
  input wire logic holding,
  input wire logic sclEdge,
  output logic expire
);

  localparam int CW = $clog2(LONG_CYC + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] limit;

  // a zero or inverted period would fire at once or never
  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_bad_period
    $error("isr_watchdog: bad timeout periods");
  end

  // period chosen by the select bit
  assign limit = longSel ? CW'(LONG_CYC) : CW'(SHORT_CYC);

  // counts only while we pull sda low and scl stands still
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      expire <= 1'b0;
    end else if (!enable || !holding || sclEdge) begin
      count <= '0;
      expire <= 1'b0;
    end else if (count >= limit - CW'(1)) begin
      count <= '0;
      expire <= 1'b1;
    end else begin
      count <= count + CW'(1);
      expire <= 1'b0;
    end
  end

endmodule : isr_watchdog

// ===== verilog/isr_slave.sv
`timescale 1ns/1ps
`include "isr_regs.svh"

// Behaviour
// - after a repeated start and our address with the read bit at one, we drive data bytes.
// - a not-acknowledge from the master stops our sending and releases sda until the next stop or start.
// - the register pointer steps by one after each byte read, so registers come out in sequence.
// - every read starts at the address from the latest write command, not where the last read ended.
// - the read start address is zero until a register address has been written.
// - a watchdog resets the slave engine when we hold the bus locked up.
// - the watchdog is enabled by one configuration bit and its period chosen by another.
// - we answer address 0x18 with the address-select pin low and 0x19 with it high.
// - multi-byte writes step the address on normal registers and hold it on trapped ones.
module isr_slave #(
  parameter int WDT_SHORT_CYC = `ISR_WDT_SHORT_CYC,
  parameter int WDT_LONG_CYC = `ISR_WDT_LONG_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic addressSelectPin,
  input wire logic wdtEnable,
  input wire logic wdtLongSel,
  output logic [7:0] regAddr,
  input wire logic [7:0] rdData,
  output logic rdFetch,
  output isr_pkg::isr_wr_t wrPort,
  output logic wrValid,
  input wire logic wrTrapped,
  output logic busy
);

  isr_pkg::isr_state_t state;
  logic sclQ;
  logic sdaQ;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [3:0] bitCnt;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic [7:0] startAddr;
  logic [7:0] ptr;
  logic driveLow;
  logic isRead;
  logic firstByte;
  logic masterAck;
  logic wdtExpire;
  logic [6:0] ownAddr;

  // trapped registers keep the pointer so a burst refills one location
  function automatic logic [7:0] nextPtr(input logic [7:0] cur,
                                         input logic hold);
    nextPtr = hold ? cur : cur + 8'h01;
  endfunction : nextPtr

  // last sample of both lines, for edge and condition detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end else begin
      sclQ <= scl;
      sdaQ <= sdaIn;
    end
  end

  // start and stop need scl high on both samples; apart from a watchdog release
  // we only move sda after a falling scl, so our own drive never fakes a condition
  assign sclRise = scl && !sclQ;
  assign sclFall = !scl && sclQ;
  assign startCond = scl && sclQ && sdaQ && !sdaIn;
  assign stopCond = scl && sclQ && !sdaQ && sdaIn;
  assign ownAddr = addressSelectPin ? `ISR_SLAVE_ADDR_HIGH
                                    : `ISR_SLAVE_ADDR_LOW;

  // open drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOeN = !driveLow;
  assign regAddr = ptr;
  assign busy = (state != isr_pkg::ST_IDLE);

  // lock-up watchdog watches our own pull-down against scl activity
  isr_watchdog #(
    .SHORT_CYC(WDT_SHORT_CYC),
    .LONG_CYC(WDT_LONG_CYC)
  ) u_wdt (
    .core_clk(core_clk),
    .nrst(nrst),
    .enable(wdtEnable),
    .longSel(wdtLongSel),
    .holding(driveLow),
    .sclEdge(sclRise || sclFall),
    .expire(wdtExpire)
  );

  // read start address survives the watchdog; it is register state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      startAddr <= `ISR_START_ADDR_RST;
    end else if (state == isr_pkg::ST_RX && sclFall && firstByte &&
                 bitCnt == `ISR_BYTE_BITS && !startCond && !stopCond &&
                 !wdtExpire) begin
      startAddr <= rxShift;
    end
  end

  // protocol engine
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= isr_pkg::ST_IDLE;
      bitCnt <= 4'h0;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      ptr <= `ISR_START_ADDR_RST;
      driveLow <= 1'b0;
      isRead <= 1'b0;
      firstByte <= 1'b0;
      masterAck <= 1'b0;
      rdFetch <= 1'b0;
      wrValid <= 1'b0;
      wrPort <= '0;
    end else begin
      rdFetch <= 1'b0;
      wrValid <= 1'b0;
      if (wdtExpire) begin
        // free the bus and wait for the next start
        state <= isr_pkg::ST_IDLE;
        driveLow <= 1'b0;
        bitCnt <= 4'h0;
      end else if (startCond) begin
        // start or repeated start: a fresh address byte follows
        state <= isr_pkg::ST_ADDR;
        bitCnt <= 4'h0;
        driveLow <= 1'b0;
      end else if (stopCond) begin
        state <= isr_pkg::ST_IDLE;
        driveLow <= 1'b0;
      end else begin
        case (state)
          isr_pkg::ST_ADDR: begin
            if (sclRise) begin
              rxShift <= {rxShift[6:0], sdaIn};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == `ISR_BYTE_BITS) begin
              if (rxShift[7:1] == ownAddr) begin
                driveLow <= 1'b1;
                isRead <= rxShift[0];
                firstByte <= !rxShift[0];
                if (rxShift[0]) begin
                  ptr <= startAddr;
                end
                state <= isr_pkg::ST_ACK;
              end else begin
                state <= isr_pkg::ST_WAIT;
              end
            end
          end
          isr_pkg::ST_ACK: begin
            // our acknowledge ends at this falling edge
            if (sclFall) begin
              if (isRead) begin
                txShift <= rdData;
                driveLow <= !rdData[7];
                bitCnt <= 4'h1;
                rdFetch <= 1'b1;
                state <= isr_pkg::ST_TX;
              end else begin
                driveLow <= 1'b0;
                bitCnt <= 4'h0;
                state <= isr_pkg::ST_RX;
              end
            end
          end
          isr_pkg::ST_RX: begin
            if (sclRise) begin
              rxShift <= {rxShift[6:0], sdaIn};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == `ISR_BYTE_BITS) begin
              driveLow <= 1'b1;
              state <= isr_pkg::ST_ACK;
              if (firstByte) begin
                // register address of the write phase
                ptr <= rxShift;
                firstByte <= 1'b0;
              end else begin
                wrPort.addr <= ptr;
                wrPort.data <= rxShift;
                wrValid <= 1'b1;
                ptr <= nextPtr(ptr, wrTrapped);
              end
            end
          end
          isr_pkg::ST_TX: begin
            // a one bit is sent by letting the pull-up win
            if (sclFall) begin
              if (bitCnt == `ISR_BYTE_BITS) begin
                driveLow <= 1'b0;
                ptr <= nextPtr(ptr, 1'b0);
                state <= isr_pkg::ST_MACK;
              end else begin
                txShift <= {txShift[6:0], 1'b0};
                driveLow <= !txShift[6];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          isr_pkg::ST_MACK: begin
            if (sclRise) begin
              masterAck <= !sdaIn;
            end else if (sclFall) begin
              if (masterAck) begin
                txShift <= rdData;
                driveLow <= !rdData[7];
                bitCnt <= 4'h1;
                rdFetch <= 1'b1;
                state <= isr_pkg::ST_TX;
              end else begin
                // not-acknowledge: hands off until stop or start
                driveLow <= 1'b0;
                state <= isr_pkg::ST_WAIT;
              end
            end
          end
          isr_pkg::ST_IDLE, isr_pkg::ST_WAIT: begin
            driveLow <= 1'b0;
          end
          default: begin
            state <= isr_pkg::ST_IDLE;
            driveLow <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : isr_slave

// ===== dv/isr_slave_props.sv
`timescale 1ns/1ps
module isr_slave_props #(
  parameter int WDT_SHORT_CYC = 20,
  parameter int WDT_LONG_CYC = 50
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOeN,
  input wire logic wdtEnable,
  input wire logic wdtLongSel,
  input wire logic [7:0] regAddr,
  input wire logic rdFetch,
  input wire logic wrValid,
  input wire logic busy
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // cycles the slave has held sda low while scl stood still
  logic sclQ;
  int lowCnt;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclQ <= 1'b0;
      lowCnt <= 0;
    end else begin
      sclQ <= scl;
      lowCnt <= (!sdaOeN && scl == sclQ) ? lowCnt + 1 : 0;
    end
  end
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  chk_od_low: assert property (!sdaOut)
    else $error("sda output drives high");
  chk_fetch_pulse: assert property (rdFetch |-> s_pulse(rdFetch))
    else $error("fetch pulse too long");
  chk_write_pulse: assert property (wrValid |-> s_pulse(wrValid))
    else $error("write pulse too long");
  chk_fetch_fall: assert property (rdFetch |-> !scl && busy)
    else $error("fetch outside scl low");
  chk_pull_low: assert property ($fell(sdaOeN) |-> !scl)
    else $error("sda pulled while scl high");
  chk_release_low: assert property (
    $rose(sdaOeN) && !wdtEnable |-> !scl)
    else $error("sda released while scl high");
  chk_idle_free: assert property (!busy |-> sdaOeN)
    else $error("sda held while idle");
  chk_reset_vals: assert property (
    $rose(nrst) |-> regAddr == 8'h00 && sdaOeN && !busy)
    else $error("bad state after reset");
  chk_wdt_short: assert property (
    wdtEnable && !wdtLongSel |-> lowCnt <= WDT_SHORT_CYC + 4)
    else $error("short watchdog late");
  chk_wdt_long: assert property (
    wdtEnable && wdtLongSel |-> lowCnt <= WDT_LONG_CYC + 4)
    else $error("long watchdog late");
endmodule : isr_slave_props
bind isr_slave isr_slave_props #(
  .WDT_SHORT_CYC(WDT_SHORT_CYC),
  .WDT_LONG_CYC(WDT_LONG_CYC)
) isr_slave_props_i (
  .core_clk, .nrst, .scl, .sdaOut, .sdaOeN, .wdtEnable, .wdtLongSel,
  .regAddr, .rdFetch, .wrValid, .busy
);

// ===== dv/isr_host.sv
`timescale 1ns/1ps
module isr_host (
  input wire logic core_clk,
  input wire logic sdaLine,
  output logic scl = 1'b1,
  output logic sdaDrv = 1'b1
);
  // each step holds both lines 3 core cycles, above the 2 the slave needs (scl high 3, low 6 per bit)
  task automatic step(logic c, logic d);
    scl <= c;
    sdaDrv <= d;
    repeat (3) @(posedge core_clk);
  endtask : step
  // start or repeated start; scl always toggles before a stop
  task automatic start();
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  // ends every transfer, also after a not-acknowledge
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  // data set while scl is low, sampled late in the high phase
  task automatic bit_x(logic b, output logic s);
    step(1'b0, b);
    step(1'b1, b);
    s = sdaLine;
    step(1'b0, b);
  endtask : bit_x
  // msb first, then the acknowledge slot
  task automatic byte_x(logic [7:0] d, logic mack, output logic [7:0] q,
                        output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(mack, a);
  endtask : byte_x
  // quiet bus after a write: 2 us in performance mode, else 450 us
  task automatic idle(logic lp);
    repeat (lp ? 45000 : 200) @(posedge core_clk);
  endtask : idle
endmodule : isr_host

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sel = 1'b0;
  logic wdtEn = 1'b0;
  logic wdtLong = 1'b0;
  logic scl, sdaDrv, sdaIn, sdaOut, sdaOeN, rdFetch, wrValid, busy;
  logic [7:0] regAddr, rdData;
  isr_pkg::isr_wr_t wrPort;
  isr_pkg::isr_wr_t wq[$];
  int n_errors = 0;
  int total_checks = 0;
  // register file answers at once; 0x7e is the one trapped register
  assign rdData = regAddr ^ 8'h25;
  // open-drain wire with its pull-up
  assign sdaIn = sdaDrv & (sdaOeN | sdaOut);
  always #5 core_clk = ~core_clk;
  // register writes as the register file sees them
  always @(posedge core_clk) if (wrValid) wq.push_back(wrPort);
  isr_slave #(.WDT_SHORT_CYC(20), .WDT_LONG_CYC(50)) isr_slave_i (
    .core_clk, .nrst, .scl, .sdaIn, .sdaOut, .sdaOeN,
    .addressSelectPin(sel), .wdtEnable(wdtEn), .wdtLongSel(wdtLong),
    .regAddr, .rdData, .rdFetch, .wrPort, .wrValid,
    .wrTrapped(regAddr == 8'h7e), .busy
  );
  isr_host isr_host_i (.core_clk, .sdaLine(sdaIn), .scl, .sdaDrv);
  task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // write phase: address byte and register address, both acknowledged
  task automatic wph(logic [6:0] dev, logic [7:0] ra);
    logic [7:0] q;
    logic a;
    isr_host_i.start();
    isr_host_i.byte_x({dev, 1'b0}, 1'b1, q, a);
    cmp("ack dev", 16'h0, 16'(a));
    isr_host_i.byte_x(ra, 1'b1, q, a);
    cmp("ack reg", 16'h0, 16'(a));
  endtask : wph
  // read n bytes from a0 on, the last one refused
  task automatic rd(logic [6:0] dev, int n, logic [7:0] a0);
    logic [7:0] q;
    logic a;
    isr_host_i.start();
    isr_host_i.byte_x({dev, 1'b1}, 1'b1, q, a);
    cmp("ack rd", 16'h0, 16'(a));
    for (int i = 0; i < n; i++) begin
      isr_host_i.byte_x(8'hff, i == n - 1, q, a);
      cmp("rd byte", 16'(8'(a0 + i) ^ 8'h25), 16'(q));
    end
    cmp("nack free", 16'h1, 16'(sdaIn));
    isr_host_i.stop();
  endtask : rd
  task automatic t_burst;
    wph(7'h18, 8'h12);
    rd(7'h18, 4, 8'h12);
  endtask : t_burst
  task automatic t_asel;
    logic [7:0] q;
    logic a;
    @(posedge core_clk) sel <= 1'b1;
    wph(7'h19, 8'h20);
    rd(7'h19, 1, 8'h20);
    isr_host_i.start();
    isr_host_i.byte_x(8'h30, 1'b1, q, a);
    cmp("ack other", 16'h1, 16'(a));
    isr_host_i.stop();
    @(posedge core_clk) sel <= 1'b0;
  endtask : t_asel
  task automatic t_write;
    logic [7:0] q;
    logic a;
    wq.delete();
    wph(7'h18, 8'h7d);
    for (int i = 1; i <= 3; i++) isr_host_i.byte_x(8'(i * 17), 1'b1, q, a);
    isr_host_i.stop();
    isr_host_i.idle(1'b0);
    cmp("writes", 16'd3, 16'(wq.size()));
    cmp("wr0", 16'h7d11, wq[0]);
    cmp("wr1", 16'h7e22, wq[1]);
    cmp("wr2", 16'h7e33, wq[2]);
  endtask : t_write
  // freeze scl while the slave acknowledges and time the release
  task automatic t_wdt(logic en, logic lng, int lo, int hi);
    logic s;
    int c;
    @(posedge core_clk) wdtEn <= en;
    wdtLong <= lng;
    isr_host_i.start();
    for (c = 0; c < 8; c++) isr_host_i.bit_x(c == 2 || c == 3, s);
    // host lets go of sda so only the slave's acknowledge holds it low
    isr_host_i.step(1'b0, 1'b1);
    for (c = 0; c < 200 && !sdaIn; c++) @(posedge core_clk);
    cmp("wdt time", 16'h1, 16'(c >= lo && c <= hi));
    cmp("busy", 16'(!en), 16'(busy));
    cmp("ptr kept", 16'h7e, 16'(regAddr));
    isr_host_i.bit_x(1'b1, s);
    isr_host_i.stop();
    @(posedge core_clk) wdtEn <= 1'b0;
  endtask : t_wdt
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(7'h18, 2, 8'h00);
    t_burst();
    rd(7'h18, 2, 8'h12);
    t_asel();
    t_write();
    isr_host_i.idle(1'b1);
    t_wdt(1'b1, 1'b0, 10, 30);
    t_wdt(1'b1, 1'b1, 35, 80);
    t_wdt(1'b0, 1'b0, 200, 200);
    end_sim();
  end
endmodule : tb_top
